// *** core/cis_pkg.sv ***
/*
 file: constants and types of the cpu interrupt sequencer.
 assumes: included before every core file; nothing is imported, names are package-qualified.
*/
`default_nettype none
package cis_pkg;
   // register byte addresses on the axi4-lite slave
   localparam logic [7:0] CIS_ENABLE_OFS = 8'h3a;    // master_irq_enable in bit 0, source enables 15:1
   localparam logic [7:0] CIS_LATCH_OFS = 8'h3c;     // request_latch, write 0 clears
   localparam logic [7:0] CIS_WDCTL_OFS = 8'h40;     // watchdog_control_reg
   localparam logic [7:0] CIS_STATUS_OFS = 8'h44;    // sequencer state, read only
   localparam logic [7:0] CIS_SP_OFS = 8'h48;        // stack pointer
   localparam logic [7:0] CIS_VECBASE_OFS = 8'h4c;   // vector table base
   localparam int CIS_MASTER_EN_BIT = 0;
   localparam int CIS_TRAP_RESET_BIT = 0;
   localparam logic [15:0] CIS_ENABLE_RST = 16'h0000;
   localparam logic [15:0] CIS_LATCH_RST = 16'h0000;
   localparam logic [7:0] CIS_SP_RST = 8'hff;
   localparam logic [15:0] CIS_VECBASE_RST = 16'hffe0;
   // acceptance length and worst-case latency in machine cycles
   localparam int CIS_ACCEPT_CYCLES = 8;
   localparam int CIS_LATENCY_MAX = 38;
   localparam logic [2:0] CIS_ACCEPT_LAST = 3'(CIS_ACCEPT_CYCLES - 1);
   localparam logic [7:0] CIS_SOFT_TRAP_OP = 8'hff;
   localparam logic [1:0] CIS_RESP_OKAY = 2'h0;
   localparam logic [1:0] CIS_RESP_SLVERR = 2'h2;
   // fixed source numbers; lower number wins among maskables
   localparam logic [3:0] CIS_SRC_SOFT = 4'h0;
   localparam logic [3:0] CIS_SRC_UNDEF = 4'h1;
   localparam logic [3:0] CIS_SRC_FTRAP = 4'h2;
   typedef enum logic [1:0] {
      CIS_IDLE = 2'b00,
      CIS_ACCEPT = 2'b01,
      CIS_RETURN = 2'b10
   } cis_state_t;
endpackage
`default_nettype wire

// *** core/cis_prio_pick.sv ***
/*
 file: fixed-priority picker over pending and enabled request latches, maskable and non-maskable.
 assumes: inputs are same-clock logic; combinational, no state.
*/
`default_nettype none
module cis_prio_pick #(
   parameter int NSRC = 16
) (
   input wire logic [NSRC-1:0] req,
   output logic any,
   output logic [3:0] idx
);
   always_comb begin
      any = 1'b0;
      idx = 4'h0;
      // scan high to low so the lowest index is left standing
      for (int i = NSRC - 1; i >= 0; i--) begin
         if (req[i]) begin
            any = 1'b1;
            idx = 4'(i);
         end
      end
   end
endmodule // cis_prio_pick
`default_nettype wire

// *** core/cis_sequencer.sv ***
/*
 file: interrupt acceptance and return sequencer with axi4-lite register slave.
 assumes: instruction sequencer pulses instr_last on the final cycle of each instruction and
 holds the accept handshake; stack and vector memories answer in the same cycle.
*/
`default_nettype none
// Functional notes
// RL1: a set request latch stays set until accepted, reset, or written zero.
// RL2: acceptance lasts exactly eight machine cycles after the instruction completes.
// RL3: maskable service ends with maskable return, non-maskable with non-maskable return.
// RL4: first acceptance step clears the master enable.
// RL5: only the accepted source's request latch is cleared.
// RL6: push status with master enable, pc high, pc low; stack pointer drops three.
// RL7: program counter loads the vector slot entry, then that instruction runs.
// RL8: enabled request reaches acceptance within thirty-eight clocks.
// RL9: master enable low blocks maskables, even higher priority ones.
// RL10: only pc and status with master enable are saved.
// RL11: both returns restore pc, status, master enable; stack pointer rises three.
// RL12: after acceptance pc low sits at sp+1, pc high at sp+2.
// RL13: requests sampled on each instruction's last cycle, also after returns.
// RL14: soft trap instruction starts soft trap service at once, top priority.
// RL15: opcode ff is the soft trap; missing single-chip fetches read ff.
// RL16: fetch from ram, data buffer or special register areas raises address trap.
// RL17: undefined opcode raises bad opcode trap, vectored like the soft trap.
// RL18: bad opcode trap taken at once, even inside non-maskable service.
// RL19: address trap taken at once, even inside non-maskable service.
// RL20: watchdog control bit picks reset output or address trap interrupt.
// RL21: unaltered non-maskable return after address trap re-enters trap area, trapping again.
// RL22: master enable low rejects maskables regardless of source enables.
// RL23: master enable is bit 0 of enable register, resets to zero.
// RL24: among pending enabled requests the fixed highest priority wins.
module cis_sequencer #(
   parameter int NSRC = 16,
   parameter logic [15:0] NMI_MASK = 16'h000f
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [NSRC-1:0] irq_set,
   input wire logic instr_last,
   input wire logic [7:0] opcode,
   input wire logic opcode_defined,
   input wire logic fetch_valid,
   input wire logic [15:0] fetch_addr,
   input wire logic fetch_exists,
   input wire logic [15:0] cur_pc,
   input wire logic [7:0] cur_status,
   input wire logic ret_maskable,
   input wire logic ret_nonmaskable,
   input wire logic [7:0] stack_rdata,
   input wire logic [7:0] vec_rdata,
   output logic accept_busy,
   output logic abort_instr,
   output logic stack_we,
   output logic [7:0] stack_addr,
   output logic [7:0] stack_wdata,
   output logic [15:0] vec_addr,
   output logic pc_load,
   output logic [15:0] pc_value,
   output logic status_load,
   output logic [7:0] status_value,
   output logic [7:0] fetch_data,
   output logic trap_reset_out,
   output logic [7:0] sp_out
);
   typedef struct packed {
      cis_pkg::cis_state_t st;
      logic [2:0] step;
      logic [3:0] src;
      logic master_irq_enable;
      logic [NSRC-1:0] source_irq_enable;
      logic [NSRC-1:0] request_latch;
      logic trap_reset_sel;
      logic [7:0] sp;
      logic [15:0] vec_base;
      logic nmi_active;
      logic [7:0] ret_status;
      logic [15:0] pc_tmp;
      logic aw_got, w_got;
      logic [7:0] aw_addr;
      logic [31:0] w_data;
      logic [3:0] w_strb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic busy, abort, swe, prog_counter_low, stl, trst;
      logic [7:0] saddr, swdata, stval, fdata;
      logic [15:0] vaddr, pcval;
   } cis_regs_t;

   cis_regs_t q_r, q_nxt;
   logic [NSRC-1:0] eligible;
   logic pick_any;
   logic [3:0] pick_idx;
   logic in_data_areas, trap_fetch, undef_now, swi_now;

   // ram below 0x0040..0x0f7f plus data buffer and special register space
   function automatic logic is_data_area(input logic [15:0] a);
      return a < 16'h1000;
   endfunction

   // nmi sources bypass the master enable; maskables need both enables
   assign eligible = q_r.request_latch & q_r.source_irq_enable &
                     ({NSRC{q_r.master_irq_enable}} | NMI_MASK); // RL9 RL22

   cis_prio_pick #(.NSRC(NSRC)) u_pick (
      .req(eligible),
      .any(pick_any),
      .idx(pick_idx)
   );

   assign in_data_areas = fetch_valid && is_data_area(fetch_addr); // RL16
   assign trap_fetch = in_data_areas;
   assign undef_now = fetch_valid && !opcode_defined && opcode != cis_pkg::CIS_SOFT_TRAP_OP; // RL17
   assign swi_now = instr_last && opcode == cis_pkg::CIS_SOFT_TRAP_OP; // RL15

   always_comb begin
      logic [31:0] rd;
      rd = 32'h0000_0000;
      q_nxt = q_r;
      q_nxt.prog_counter_low = 1'b0;
      q_nxt.stl = 1'b0;
      q_nxt.swe = 1'b0;
      q_nxt.abort = 1'b0;
      q_nxt.fdata = fetch_exists ? opcode : cis_pkg::CIS_SOFT_TRAP_OP; // RL15
      q_nxt.trst = q_r.trst | (trap_fetch & q_r.trap_reset_sel); // RL20

      // axi write: address and data in either order, response after both
      if (s_axi_awvalid && !q_r.aw_got) begin
         q_nxt.aw_got = 1'b1;
         q_nxt.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && !q_r.w_got) begin
         q_nxt.w_got = 1'b1;
         q_nxt.w_data = s_axi_wdata;
         q_nxt.w_strb = s_axi_wstrb;
      end
      if (q_r.aw_got && q_r.w_got && !q_r.bvalid) begin
         q_nxt.aw_got = 1'b0;
         q_nxt.w_got = 1'b0;
         q_nxt.bvalid = 1'b1;
         q_nxt.bresp = cis_pkg::CIS_RESP_OKAY;
         case (q_r.aw_addr)
            cis_pkg::CIS_ENABLE_OFS: begin
               if (q_r.w_strb[0]) begin
                  q_nxt.master_irq_enable = q_r.w_data[cis_pkg::CIS_MASTER_EN_BIT]; // RL23
               end
               q_nxt.source_irq_enable = q_r.w_data[NSRC-1:0];
            end
            cis_pkg::CIS_LATCH_OFS: q_nxt.request_latch = q_r.request_latch & q_r.w_data[NSRC-1:0]; // RL1
            cis_pkg::CIS_WDCTL_OFS: q_nxt.trap_reset_sel = q_r.w_data[cis_pkg::CIS_TRAP_RESET_BIT];
            cis_pkg::CIS_SP_OFS: q_nxt.sp = q_r.w_data[7:0];
            cis_pkg::CIS_VECBASE_OFS: q_nxt.vec_base = q_r.w_data[15:0];
            default: q_nxt.bresp = cis_pkg::CIS_RESP_SLVERR;
         endcase
      end
      if (q_r.bvalid && s_axi_bready) begin
         q_nxt.bvalid = 1'b0;
      end

      // axi read
      if (s_axi_arvalid && !q_r.rvalid) begin
         q_nxt.rvalid = 1'b1;
         q_nxt.rresp = cis_pkg::CIS_RESP_OKAY;
         case (s_axi_araddr)
            cis_pkg::CIS_ENABLE_OFS: rd = 32'({q_r.source_irq_enable[NSRC-1:1], q_r.master_irq_enable});
            cis_pkg::CIS_LATCH_OFS: rd = 32'(q_r.request_latch);
            cis_pkg::CIS_WDCTL_OFS: rd = 32'(q_r.trap_reset_sel);
            cis_pkg::CIS_STATUS_OFS: rd = 32'({q_r.nmi_active, q_r.src, q_r.step, q_r.st});
            cis_pkg::CIS_SP_OFS: rd = 32'(q_r.sp);
            cis_pkg::CIS_VECBASE_OFS: rd = 32'(q_r.vec_base);
            default: q_nxt.rresp = cis_pkg::CIS_RESP_SLVERR;
         endcase
         q_nxt.rdata = rd;
      end else if (q_r.rvalid && s_axi_rready) begin
         q_nxt.rvalid = 1'b0;
      end

      // new requests set latches; set wins over a software clear
      q_nxt.request_latch = q_nxt.request_latch | irq_set; // RL1

      case (q_r.st)
         cis_pkg::CIS_IDLE: begin
            q_nxt.busy = 1'b0;
            if (trap_fetch && !q_r.trap_reset_sel) begin
               q_nxt.request_latch[cis_pkg::CIS_SRC_FTRAP] = 1'b1; // RL19 RL21
            end
            if (undef_now) begin
               q_nxt.request_latch[cis_pkg::CIS_SRC_UNDEF] = 1'b1; // RL18
            end
            if (swi_now) begin
               q_nxt.request_latch[cis_pkg::CIS_SRC_SOFT] = 1'b1; // RL14
            end
            if (ret_maskable || ret_nonmaskable) begin
               q_nxt.st = cis_pkg::CIS_RETURN; // RL3
               q_nxt.step = 3'h0;
               q_nxt.busy = 1'b1;
            end else if ((trap_fetch && !q_r.trap_reset_sel) || undef_now) begin
               // immediate traps break the current instruction
               q_nxt.abort = 1'b1; // RL18 RL19
               q_nxt.st = cis_pkg::CIS_ACCEPT;
               q_nxt.step = 3'h0;
               q_nxt.busy = 1'b1;
               q_nxt.src = undef_now ? cis_pkg::CIS_SRC_UNDEF : cis_pkg::CIS_SRC_FTRAP;
            end else if (swi_now || (instr_last && pick_any)) begin
               q_nxt.st = cis_pkg::CIS_ACCEPT; // RL13 RL8
               q_nxt.step = 3'h0;
               q_nxt.busy = 1'b1;
               q_nxt.src = swi_now ? cis_pkg::CIS_SRC_SOFT : pick_idx; // RL14 RL24
            end
         end
         cis_pkg::CIS_ACCEPT: begin
            q_nxt.step = q_r.step + 3'h1;
            case (q_r.step)
               3'h0: begin
                  q_nxt.ret_status = {cur_status[7:1], q_r.master_irq_enable};
                  q_nxt.master_irq_enable = 1'b0; // RL4
                  // a fresh request in the clearing cycle stays pending
                  q_nxt.request_latch[q_r.src] = irq_set[q_r.src]; // RL5 RL1
                  q_nxt.pc_tmp = cur_pc;
               end
               3'h1: begin
                  // only status with master enable and pc go to the stack
                  q_nxt.swe = 1'b1; // RL6 RL10
                  q_nxt.saddr = q_r.sp;
                  q_nxt.swdata = q_r.ret_status;
               end
               3'h2: begin
                  q_nxt.swe = 1'b1; // RL6 RL12
                  q_nxt.saddr = q_r.sp - 8'h01;
                  q_nxt.swdata = q_r.pc_tmp[15:8];
               end
               3'h3: begin
                  q_nxt.swe = 1'b1; // RL6 RL12
                  q_nxt.saddr = q_r.sp - 8'h02;
                  q_nxt.swdata = q_r.pc_tmp[7:0];
                  q_nxt.sp = q_r.sp - 8'h03;
               end
               3'h4: q_nxt.vaddr = q_r.vec_base + {11'h000, q_r.src, 1'b0}; // RL7
               3'h5: begin
                  q_nxt.pc_tmp[7:0] = vec_rdata;
                  q_nxt.vaddr = q_r.vaddr + 16'h0001;
               end
               3'h6: q_nxt.pc_tmp[15:8] = vec_rdata;
               default: begin
                  q_nxt.prog_counter_low = 1'b1; // RL2 RL7
                  q_nxt.pcval = q_r.pc_tmp;
                  q_nxt.nmi_active = NMI_MASK[q_r.src];
                  q_nxt.busy = 1'b0;
                  q_nxt.st = cis_pkg::CIS_IDLE;
               end
            endcase
         end
         cis_pkg::CIS_RETURN: begin
            q_nxt.step = q_r.step + 3'h1;
            case (q_r.step)
               3'h0: q_nxt.saddr = q_r.sp + 8'h01;
               3'h1: begin
                  q_nxt.pc_tmp[7:0] = stack_rdata;
                  q_nxt.saddr = q_r.sp + 8'h02;
               end
               3'h2: begin
                  q_nxt.pc_tmp[15:8] = stack_rdata;
                  q_nxt.saddr = q_r.sp + 8'h03;
               end
               default: begin
                  q_nxt.stval = stack_rdata; // RL11
                  q_nxt.stl = 1'b1;
                  q_nxt.master_irq_enable = stack_rdata[cis_pkg::CIS_MASTER_EN_BIT];
                  q_nxt.prog_counter_low = 1'b1;
                  q_nxt.pcval = q_r.pc_tmp; // RL21
                  q_nxt.sp = q_r.sp + 8'h03;
                  q_nxt.nmi_active = 1'b0;
                  q_nxt.busy = 1'b0;
                  q_nxt.st = cis_pkg::CIS_IDLE;
               end
            endcase
         end
         default: q_nxt.st = cis_pkg::CIS_IDLE;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         q_r <= '0;
         q_r.source_irq_enable <= cis_pkg::CIS_ENABLE_RST;
         q_r.request_latch <= cis_pkg::CIS_LATCH_RST;
         q_r.master_irq_enable <= 1'b0; // RL23
         q_r.sp <= cis_pkg::CIS_SP_RST;
         q_r.vec_base <= cis_pkg::CIS_VECBASE_RST;
         q_r.st <= cis_pkg::CIS_IDLE;
      end else begin
         q_r <= q_nxt;
      end
   end

   assign s_axi_awready = !q_r.aw_got;
   assign s_axi_wready = !q_r.w_got;
   assign s_axi_bvalid = q_r.bvalid;
   assign s_axi_bresp = q_r.bresp;
   assign s_axi_arready = !q_r.rvalid;
   assign s_axi_rvalid = q_r.rvalid;
   assign s_axi_rdata = q_r.rdata;
   assign s_axi_rresp = q_r.rresp;
   assign accept_busy = q_r.busy;
   assign abort_instr = q_r.abort;
   assign stack_we = q_r.swe;
   assign stack_addr = q_r.saddr;
   assign stack_wdata = q_r.swdata;
   assign vec_addr = q_r.vaddr;
   assign pc_load = q_r.prog_counter_low;
   assign pc_value = q_r.pcval;
   assign status_load = q_r.stl;
   assign status_value = q_r.stval;
   assign fetch_data = q_r.fdata;
   assign trap_reset_out = q_r.trst;
   assign sp_out = q_r.sp;

   // accept lasts exactly eight cycles
   accept_len_a: assert property (@(posedge aclk) disable iff (!aresetn)
      $rose(q_r.st == cis_pkg::CIS_ACCEPT) |-> (q_r.st == cis_pkg::CIS_ACCEPT) [*8] ##1 q_r.prog_counter_low)
      else $error("acceptance not eight cycles"); // RL2
   mie_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
      q_r.st == cis_pkg::CIS_ACCEPT && q_r.step == 3'h1 |-> !q_r.master_irq_enable)
      else $error("master enable not cleared"); // RL4
   sp_drop_a: assert property (@(posedge aclk) disable iff (!aresetn)
      q_r.st == cis_pkg::CIS_ACCEPT && q_r.step == 3'h0 |-> ##4 q_r.sp == $past(q_r.sp, 4) - 8'h03)
      else $error("stack pointer not down three"); // RL6
   sp_rise_a: assert property (@(posedge aclk) disable iff (!aresetn)
      $rose(q_r.st == cis_pkg::CIS_RETURN) |-> ##4 q_r.sp == $past(q_r.sp, 4) + 8'h03)
      else $error("stack pointer not up three"); // RL11
   mask_block_a: assert property (@(posedge aclk) disable iff (!aresetn)
      q_r.st == cis_pkg::CIS_IDLE && q_nxt.st == cis_pkg::CIS_ACCEPT && !q_r.master_irq_enable
      |-> NMI_MASK[q_nxt.src])
      else $error("maskable taken while disabled"); // RL9
   latch_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
      irq_set[5] |=> q_r.request_latch[5])
      else $error("request latch lost"); // RL1
   undef_go_a: assert property (@(posedge aclk) disable iff (!aresetn)
      q_r.st == cis_pkg::CIS_IDLE && undef_now && !ret_maskable && !ret_nonmaskable
      |=> q_r.st == cis_pkg::CIS_ACCEPT && q_r.abort)
      else $error("undefined opcode not taken"); // RL18
   trap_sel_a: assert property (@(posedge aclk) disable iff (!aresetn)
      trap_fetch && q_r.trap_reset_sel |=> trap_reset_out)
      else $error("trap reset not raised"); // RL20
   miss_ff_a: assert property (@(posedge aclk) disable iff (!aresetn)
      !fetch_exists |=> fetch_data == cis_pkg::CIS_SOFT_TRAP_OP)
      else $error("missing fetch not ff"); // RL15
   accept_cv: cover property (@(posedge aclk) disable iff (!aresetn) q_r.prog_counter_low && q_r.st == cis_pkg::CIS_IDLE);
   return_cv: cover property (@(posedge aclk) disable iff (!aresetn) q_r.stl);
   trap_cv: cover property (@(posedge aclk) disable iff (!aresetn) q_r.abort);
endmodule // cis_sequencer
`default_nettype wire

// *** sim/cis_far_model.sv ***
/*
 far-side model: stack memory and vector table seen by the interrupt sequencer.
 assumes: stack writes land on the rising aclk edge; reads answer in the same cycle.
*/
`default_nettype none
module cis_far_model (
   input wire logic aclk,
   input wire logic stack_we,
   input wire logic [7:0] stack_addr,
   input wire logic [7:0] stack_wdata,
   input wire logic [15:0] vec_addr,
   output logic [7:0] stack_rdata,
   output logic [7:0] vec_rdata
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] mem [256];
   always @(posedge aclk) begin
      if (stack_we) mem[stack_addr] <= stack_wdata;
   end
   // unwritten places stay unknown, so a read from a wrong slot shows up
   assign stack_rdata = mem[stack_addr];
   // both bytes of a slot match, so byte order cannot hide a wrong slot
   assign vec_rdata = {4'ha, vec_addr[4:1]};
endmodule // cis_far_model
`default_nettype wire

// *** sim/tb_top.sv ***
/*
 tb_top: self-checking bench for the interrupt sequencer.
 assumes: cis_pkg and core files compiled first; far model serves stack and vectors.
*/
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic aclk = 1'h0;
   logic aresetn = 1'h0;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00, opcode = 8'h00, cur_status = 8'h00;
   logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
   logic [31:0] wdata = 32'h0;
   logic [15:0] irq_set = 16'h0, fetch_addr = 16'h0, cur_pc = 16'h0;
   logic instr_last = 1'h0, opcode_defined = 1'h1, fetch_valid = 1'h0, fetch_exists = 1'h1;
   logic ret_m = 1'h0, ret_n = 1'h0;
   logic awready, wready, bvalid, arready, rvalid, accept_busy, abort_instr, stack_we, pc_load;
   logic status_load, trap_reset_out;
   logic [1:0] bresp, rresp, rr;
   logic [31:0] rdata, rd;
   logic [7:0] stack_addr, stack_wdata, stack_rdata, vec_rdata, status_value, fetch_data, sp_out;
   logic [15:0] vec_addr, pc_value;
   int errors = 0, checks = 0, busy_n = 0;
   bit acc_seen = 1'b0;
   integer seed = 32'hb0c8a210;
   logic [7:0] sp = 8'hff;
   logic [16:0] stq[$], exp_st;
   logic [15:0] pcq[$], saved[$];
   always #5 aclk = ~aclk;
   cis_sequencer i_cis_sequencer (
      .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .irq_set(irq_set), .instr_last(instr_last), .opcode(opcode),
      .opcode_defined(opcode_defined), .fetch_valid(fetch_valid), .fetch_addr(fetch_addr),
      .fetch_exists(fetch_exists), .cur_pc(cur_pc), .cur_status(cur_status), .ret_maskable(ret_m),
      .ret_nonmaskable(ret_n), .stack_rdata(stack_rdata), .vec_rdata(vec_rdata), .accept_busy(accept_busy),
      .abort_instr(abort_instr), .stack_we(stack_we), .stack_addr(stack_addr), .stack_wdata(stack_wdata),
      .vec_addr(vec_addr), .pc_load(pc_load), .pc_value(pc_value), .status_load(status_load),
      .status_value(status_value), .fetch_data(fetch_data), .trap_reset_out(trap_reset_out), .sp_out(sp_out));
   cis_far_model i_cis_far_model (.aclk(aclk), .stack_we(stack_we), .stack_addr(stack_addr),
      .stack_wdata(stack_wdata), .vec_addr(vec_addr), .stack_rdata(stack_rdata), .vec_rdata(vec_rdata));
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         errors++;
         $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
      end
   endtask
   task results();
      $display("errors=%0d checks=%0d", errors, checks);
      if (errors == 0 && checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // ready is looked at on the falling edge, so the handshake edge is never raced
   task axw(input logic [7:0] a, input logic [31:0] d);
      logic ta, tw, tbv;
      tbv = 1'h0;
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
      while (!tbv) begin
         @(negedge aclk);
         ta = awvalid && awready;
         tw = wvalid && wready;
         tbv = bvalid;
         @(posedge aclk);
         if (ta) awvalid <= 1'h0;
         if (tw) wvalid <= 1'h0;
         if (tbv) bready <= 1'h0;
      end
   endtask
   task axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      logic ta, tv;
      tv = 1'h0;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'h1;
      rready <= 1'h1;
      while (!tv) begin
         @(negedge aclk);
         ta = arvalid && arready;
         tv = rvalid;
         d = rdata;
         r = rresp;
         @(posedge aclk);
         if (ta) arvalid <= 1'h0;
         if (tv) rready <= 1'h0;
      end
   endtask
   task rdc(input logic [7:0] a, input logic [31:0] e);
      axr(a, rd, rr);
      chk(rd, e);
   endtask
   task last(input logic [7:0] op, input logic def);
      @(posedge aclk);
      instr_last <= 1'h1;
      opcode <= op;
      opcode_defined <= def;
      cur_pc <= 16'($random(seed));
      cur_status <= 8'($random(seed));
      @(posedge aclk);
      instr_last <= 1'h0;
      opcode_defined <= 1'h1;
      opcode <= 8'h00;
   endtask
   task ftch(input logic [15:0] a, input logic ex);
      @(posedge aclk);
      fetch_valid <= 1'h1;
      fetch_addr <= a;
      fetch_exists <= ex;
      cur_pc <= 16'($random(seed));
      @(posedge aclk);
      fetch_valid <= 1'h0;
      fetch_exists <= 1'h1;
   endtask
   // status byte layout is the designer's, so only its address is compared
   task accept(input logic [3:0] src);
      stq.push_back({1'h0, sp, 8'h00});
      stq.push_back({1'h1, sp - 8'h01, cur_pc[15:8]});
      stq.push_back({1'h1, sp - 8'h02, cur_pc[7:0]});
      pcq.push_back({2{4'ha, src}});
      saved.push_back(cur_pc);
      sp = sp - 8'h03;
      for (int n = 0; n < 60 && pcq.size() != 0; n++) @(negedge aclk);
      chk(sp_out, sp);
   endtask
   task ret(input logic nm);
      @(posedge aclk);
      ret_m <= !nm;
      ret_n <= nm;
      pcq.push_back(saved.pop_back());
      sp = sp + 8'h03;
      @(posedge aclk);
      ret_m <= 1'h0;
      ret_n <= 1'h0;
      for (int n = 0; n < 60 && pcq.size() != 0; n++) @(negedge aclk);
      chk(sp_out, sp);
   endtask
   always @(negedge aclk) begin
      if (aresetn) begin
         if (stack_we) begin
            exp_st = (stq.size() != 0) ? stq.pop_front() : 17'h1ffff;
            chk({stack_addr, exp_st[16] ? stack_wdata : 8'h00}, exp_st[15:0]);
         end
         if (pc_load) chk(pc_value, (pcq.size() != 0) ? pcq.pop_front() : 16'hxxxx);
         if (accept_busy) begin
            busy_n++;
            if (stack_we) acc_seen = 1'b1;
         end else if (busy_n != 0) begin
            // a run with stack writes is an acceptance, else a four-cycle return
            chk(busy_n, acc_seen ? cis_pkg::CIS_ACCEPT_CYCLES : 4);
            busy_n = 0;
            acc_seen = 1'b0;
         end
      end
   end
   initial begin
      repeat (5000) @(posedge aclk);
      errors++;
      results();
   end
   initial begin
      repeat (4) @(posedge aclk);
      aresetn <= 1'h1;
      rdc(cis_pkg::CIS_ENABLE_OFS, 32'h0);
      rdc(cis_pkg::CIS_SP_OFS, 32'hff);
      axr(8'h80, rd, rr);
      chk(rr, cis_pkg::CIS_RESP_SLVERR);
      axw(cis_pkg::CIS_ENABLE_OFS, 32'h00a0);
      @(posedge aclk);
      irq_set <= 16'h00a0;
      @(posedge aclk);
      irq_set <= 16'h0;
      last(8'h00, 1'h1);
      repeat (10) @(negedge aclk);
      chk(accept_busy, 1'h0);
      rdc(cis_pkg::CIS_LATCH_OFS, 32'h00a0);
      axw(cis_pkg::CIS_ENABLE_OFS, 32'h00a1);
      last(8'h00, 1'h1);
      accept(4'h5);
      rdc(cis_pkg::CIS_ENABLE_OFS, 32'h00a0);
      rdc(cis_pkg::CIS_LATCH_OFS, 32'h0080);
      ret(1'h0);
      rdc(cis_pkg::CIS_ENABLE_OFS, 32'h00a1);
      last(8'h00, 1'h1);
      accept(4'h7);
      ret(1'h0);
      last(cis_pkg::CIS_SOFT_TRAP_OP, 1'h1);
      accept(cis_pkg::CIS_SRC_SOFT);
      ftch(16'h0f80, 1'h1);
      accept(cis_pkg::CIS_SRC_FTRAP);
      // the bad opcode trap is raised by the fetch of an undefined code
      @(posedge aclk);
      fetch_valid <= 1'h1;
      fetch_addr <= 16'h8000;
      opcode <= 8'h5a;
      opcode_defined <= 1'h0;
      cur_pc <= 16'($random(seed));
      @(posedge aclk);
      fetch_valid <= 1'h0;
      opcode <= 8'h00;
      opcode_defined <= 1'h1;
      accept(cis_pkg::CIS_SRC_UNDEF);
      ret(1'h1);
      ret(1'h1);
      ret(1'h1);
      ftch(16'h8000, 1'h0);
      @(negedge aclk);
      chk(fetch_data, cis_pkg::CIS_SOFT_TRAP_OP);
      axw(cis_pkg::CIS_WDCTL_OFS, 32'h1);
      ftch(16'h0010, 1'h1);
      repeat (4) @(negedge aclk);
      chk(trap_reset_out, 1'h1);
      chk(accept_busy, 1'h0);
      results();
   end
endmodule // tb_top
`default_nettype wire
